// file: hw/opc_onoff_ctrl.sv
/*
 * On/off power state controller with on-key debounce, manual hard reset,
 * factory-ship handling, pullup and always-on rail selection.
 * Assumes all inputs are synchronous to sys_clk_i; the host register file
 * sits outside and applies config_register_reset_o to its own fields.
 */
`timescale 1ns/1ps

module opc_onoff_ctrl
    import opc_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES,
    parameter int unsigned MRST_SHORT = MRST_SHORT_TICKS,
    parameter int unsigned MRST_LONG = MRST_LONG_TICKS,
    parameter int unsigned SHIP_EXIT = SHIP_EXIT_TICKS
) (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // On-key pin and charger quality.
    input wire logic on_key_n_i,
    input wire logic [1:0] charger_input_quality_i,
    // Monitors, resources and host configuration.
    input wire opc_mon_t mon_i,
    input wire opc_res_t res_i,
    input wire opc_cfg_t cfg_i,
    // Controller state and control outputs.
    output opc_state_t state_o,
    output logic bias_enable_o,
    output logic bias_sample_hold_o,
    output logic battery_connect_o,
    output logic ship_sys_from_charger_o,
    output logic host_access_enable_o,
    output logic config_register_reset_o,
    // On-key status, key pullup and always-on rail outputs.
    output logic key_level_status_o,
    output logic key_rise_interrupt_o,
    output logic key_fall_interrupt_o,
    output logic regulator_wake_flag_o,
    output logic long_press_reset_flag_o,
    output logic key_pullup_strong_o,
    output logic always_on_from_charger_o
);

    // Tick divider: one-cycle enable every 100us.
    // The divider free-runs from reset, so a changed input may wait up to one
    // whole tick period before the controller acts on it.
    logic [CNT_W-1:0] tick_cnt;
    logic [CNT_W-1:0] next_tick_cnt;
    logic tick;

    always_comb begin
        tick = (tick_cnt == CNT_W'(TICK_DIV - 1));
        next_tick_cnt = tick ? '0 : tick_cnt + 1'b1;
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tick_cnt <= '0;
        end else begin
            tick_cnt <= next_tick_cnt;
        end
    end

    // Key debounce: a new level is accepted after it has stood for the
    // selected number of ticks; both edges are treated alike.
    // Limitation: the window counts whole ticks, so the accepted delay may fall
    // up to one tick short of the nominal debounce time.
    logic key_db;
    logic next_key_db;
    logic [CNT_W-1:0] db_cnt;
    logic [CNT_W-1:0] next_db_cnt;
    logic [CNT_W-1:0] db_limit;
    logic key_rise;
    logic key_fall;

    always_comb begin
        db_limit = cfg_i.key_debounce_select ? CNT_W'(DB_LONG_TICKS)
                                             : CNT_W'(DB_SHORT_TICKS);
        next_key_db = key_db;
        next_db_cnt = db_cnt;
        key_rise = 1'b0;
        key_fall = 1'b0;
        if (on_key_n_i == key_db) begin
            // Pin agrees with the accepted level; restart the window.
            next_db_cnt = '0;
        end else if (tick) begin
            if (db_cnt + 1'b1 >= db_limit) begin
                next_key_db = on_key_n_i;
                next_db_cnt = '0;
                key_rise = on_key_n_i;
                key_fall = !on_key_n_i;
            end else begin
                next_db_cnt = db_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            key_db <= 1'b1;
            db_cnt <= '0;
        end else begin
            key_db <= next_key_db;
            db_cnt <= next_db_cnt;
        end
    end

    // Manual reset timer and ship exit hold counter, both in ticks.
    logic [CNT_W-1:0] mrst_cnt;
    logic [CNT_W-1:0] next_mrst_cnt;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] next_hold_cnt;
    logic mrst_counting;
    logic mrst_hit;
    logic key_exit;
    opc_state_t state;
    opc_state_t next_state;

    always_comb begin
        // The timer stays at zero in ship, where the key may only ask for exit.
        // Push-button counts a held low, slide-switch a held high.
        mrst_counting = cfg_i.key_switch_type ? key_db : !key_db;
        mrst_hit = 1'b0;
        next_mrst_cnt = mrst_cnt;
        if (!mrst_counting || state == OPC_SHIP) begin
            next_mrst_cnt = '0;
        end else if (tick) begin
            if (mrst_cnt + 1'b1 >= (cfg_i.hard_reset_time_select ? CNT_W'(MRST_LONG)
                                                                 : CNT_W'(MRST_SHORT))) begin
                mrst_hit = 1'b1;
                next_mrst_cnt = '0;
            end else begin
                next_mrst_cnt = mrst_cnt + 1'b1;
            end
        end
        // The extra hold starts only after the key press is debounced.
        // The count saturates, so the exit stays armed until the rail decays.
        key_exit = 1'b0;
        next_hold_cnt = hold_cnt;
        if (key_db || state != OPC_SHIP) begin
            next_hold_cnt = '0;
        end else if (tick) begin
            if (hold_cnt + 1'b1 >= CNT_W'(SHIP_EXIT)) begin
                key_exit = 1'b1;
                next_hold_cnt = hold_cnt;
            end else begin
                next_hold_cnt = hold_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mrst_cnt <= '0;
            hold_cnt <= '0;
        end else begin
            mrst_cnt <= next_mrst_cnt;
            hold_cnt <= next_hold_cnt;
        end
    end

    // Controller state, flags and charger quality history.
    logic wake;
    logic next_wake;
    logic mrst_flag;
    logic next_mrst_flag;
    logic config_register_reset;
    logic next_config_register_reset;
    logic ship_chg;
    logic next_ship_chg;
    logic [1:0] qual_prev;
    logic [1:0] next_qual_prev;
    logic charger_ok;
    logic resource_on;
    logic off_event;
    logic ship_req;
    logic chg_exit;

    always_comb begin
        charger_ok = (charger_input_quality_i == CHG_QUAL_VALID);
        resource_on = charger_ok || (res_i.monitor_mux_select != MUX_OFF)
            || res_i.regulator_enable
            || (res_i.sink_master_enable && res_i.sink_full_scale != SINK_FS_OFF)
            || wake;
        off_event = mon_i.sys_uv || mon_i.sys_ov || mon_i.over_temp || mrst_flag
            || mon_i.supervisor_timeout_flag
            || cfg_i.software_power_request == SWREQ_OFF;
        ship_req = (cfg_i.software_power_request == SWREQ_SHIP);
        chg_exit = (qual_prev == CHG_QUAL_NONE) && charger_ok;
        next_state = state;
        next_wake = wake;
        next_mrst_flag = mrst_flag || mrst_hit;
        next_config_register_reset = 1'b0;
        next_ship_chg = ship_chg;
        next_qual_prev = tick ? charger_input_quality_i : qual_prev;
        // A debounced press wakes the regulator outside ship; it beats the off-event clear but not the ship-entry clear.
        if (tick && key_fall && state != OPC_SHIP) begin
            next_wake = 1'b1;
        end
        if (tick) begin
            case (state)
                OPC_SHIP: begin
                    // Battery loss clears ship at once; other exits wait for
                    // the rail to decay.
                    if (mon_i.battery_node_low) begin
                        next_state = OPC_SHUTDOWN;
                    end else if (mon_i.sys_low && (chg_exit || key_exit)) begin
                        next_state = OPC_SHUTDOWN;
                        next_wake = key_exit;
                    end
                    next_ship_chg = ship_chg && charger_ok;
                end
                default: begin
                    if (mon_i.supervisor_timeout_flag || mrst_flag) begin
                        next_config_register_reset = 1'b1;
                    end
                    if (ship_req) begin
                        next_state = OPC_SHIP;
                        next_ship_chg = charger_ok;
                        next_config_register_reset = 1'b1;
                        next_wake = 1'b0;
                    end else if (off_event) begin
                        // Lower-power transition is taken first.
                        next_state = OPC_SHUTDOWN;
                        // A key fall or long press in the same tick is kept:
                        // the set wins over the clear, so no event is lost.
                        next_wake = key_fall;
                        next_mrst_flag = mrst_hit;
                    end else if (state == OPC_SHUTDOWN) begin
                        if (resource_on) begin
                            next_state = OPC_STANDBY;
                        end
                    end else if (state == OPC_STANDBY) begin
                        next_state = resource_on ? OPC_RES_ON : OPC_SHUTDOWN;
                    end else if (!resource_on) begin
                        next_state = OPC_SHUTDOWN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= OPC_SHUTDOWN;
            wake <= 1'b0;
            mrst_flag <= 1'b0;
            config_register_reset <= 1'b0;
            ship_chg <= 1'b0;
            qual_prev <= CHG_QUAL_NONE;
        end else begin
            state <= next_state;
            wake <= next_wake;
            mrst_flag <= next_mrst_flag;
            config_register_reset <= next_config_register_reset;
            ship_chg <= next_ship_chg;
            qual_prev <= next_qual_prev;
        end
    end

    // Outputs; edge pulses (one clock, decoded from on_key_n_i) and pullup, always-on and sample-hold follow inputs directly; the rest come from registers.
    // Host access drops in ship; the register file outside must refuse cycles.
    always_comb begin
        state_o = state;
        bias_enable_o = (state == OPC_STANDBY) || (state == OPC_RES_ON);
        bias_sample_hold_o = bias_enable_o && cfg_i.bias_low_power;
        battery_connect_o = (state != OPC_SHIP);
        ship_sys_from_charger_o = (state == OPC_SHIP) && ship_chg;
        host_access_enable_o = (state != OPC_SHIP);
        config_register_reset_o = config_register_reset;
        key_level_status_o = key_db;
        key_rise_interrupt_o = tick && key_rise;
        key_fall_interrupt_o = tick && key_fall;
        regulator_wake_flag_o = wake;
        long_press_reset_flag_o = mrst_flag;
        key_pullup_strong_o = !cfg_i.key_pullup_weak;
        always_on_from_charger_o = charger_ok && !cfg_i.input_suspend;
    end

endmodule : opc_onoff_ctrl

// file: hw/opc_pkg.sv
/*
 * Package for the on/off power state controller: timing constants, state
 * enumeration and the packed groups of request and status signals.
 * Assumes a 100 MHz system clock from which the 100 us tick is derived.
 */
package opc_pkg;

    // System clock period in nanoseconds.
    localparam int unsigned CLK_PERIOD_NS = 10;
    // Controller tick period in microseconds.
    localparam int unsigned TICK_US = 100;
    // System clocks per controller tick.
    localparam int unsigned TICK_CYCLES = (TICK_US * 1000) / CLK_PERIOD_NS;

    // Short on-key debounce time in microseconds.
    localparam int unsigned DB_SHORT_US = 200;
    // Long on-key debounce time in milliseconds.
    localparam int unsigned DB_LONG_MS = 30;
    // Extra hold time to leave factory-ship, in milliseconds.
    localparam int unsigned SHIP_EXIT_MS = 250;
    // Manual reset times in seconds.
    localparam int unsigned MRST_SHORT_S = 8;
    localparam int unsigned MRST_LONG_S = 16;

    // Tick counts derived from the times above (least times, so round up).
    localparam int unsigned DB_SHORT_TICKS = (DB_SHORT_US + TICK_US - 1) / TICK_US;
    localparam int unsigned DB_LONG_TICKS = (DB_LONG_MS * 1000 + TICK_US - 1) / TICK_US;
    localparam int unsigned SHIP_EXIT_TICKS = (SHIP_EXIT_MS * 1000 + TICK_US - 1) / TICK_US;
    localparam int unsigned MRST_SHORT_TICKS = (MRST_SHORT_S * 1000000) / TICK_US;
    localparam int unsigned MRST_LONG_TICKS = (MRST_LONG_S * 1000000) / TICK_US;

    // Width of the tick-domain counters.
    localparam int unsigned CNT_W = 18;

    // Field encodings.
    localparam logic [1:0] SWREQ_OFF = 2'h2;
    localparam logic [1:0] SWREQ_SHIP = 2'h3;
    localparam logic [1:0] CHG_QUAL_VALID = 2'h3;
    localparam logic [1:0] CHG_QUAL_NONE = 2'h0;
    localparam logic [3:0] MUX_OFF = 4'h0;
    localparam logic [1:0] SINK_FS_OFF = 2'h0;

    // Top-level controller states.
    typedef enum logic [1:0] {
        OPC_SHUTDOWN,
        OPC_STANDBY,
        OPC_RES_ON,
        OPC_SHIP
    } opc_state_t;

    // Analog and protection conditions seen by the controller.
    typedef struct packed {
        logic sys_uv;
        logic sys_ov;
        logic over_temp;
        logic sys_low;
        logic battery_node_low;
        logic supervisor_timeout_flag;
    } opc_mon_t;

    // Resource enables that keep the controller in resource-on.
    typedef struct packed {
        logic [3:0] monitor_mux_select;
        logic regulator_enable;
        logic sink_master_enable;
        logic [1:0] sink_full_scale;
    } opc_res_t;

    // Configuration bits written by the host.
    typedef struct packed {
        logic [1:0] software_power_request;
        logic key_debounce_select;
        logic hard_reset_time_select;
        logic key_switch_type;
        logic key_pullup_weak;
        logic input_suspend;
        logic bias_low_power;
    } opc_cfg_t;

endpackage : opc_pkg

// file: test/opc_onoff_ctrl_chk.sv
/*
 * Checker for the on/off power state controller, bound to its top ports.
 * Assumes one clock domain and the scaled tick of ten system clocks.
 */
`timescale 1ns/1ps
module opc_onoff_ctrl_chk
    import opc_pkg::*;
(
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // Watched inputs.
    input wire logic [1:0] charger_input_quality_i,
    input wire opc_mon_t mon_i,
    input wire opc_cfg_t cfg_i,
    // Watched outputs.
    input wire opc_state_t state_o,
    input wire logic bias_enable_o,
    input wire logic bias_sample_hold_o,
    input wire logic battery_connect_o,
    input wire logic host_access_enable_o,
    input wire logic config_register_reset_o,
    input wire logic key_level_status_o,
    input wire logic key_rise_interrupt_o,
    input wire logic key_fall_interrupt_o,
    input wire logic key_pullup_strong_o,
    input wire logic always_on_from_charger_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    a_pullup_follows: assert property (key_pullup_strong_o == !cfg_i.key_pullup_weak)
        else $error("pullup strength wrong");
    a_aon_source: assert property (always_on_from_charger_o ==
        (charger_input_quality_i == CHG_QUAL_VALID && !cfg_i.input_suspend))
        else $error("always-on source wrong");
    a_sample_hold: assert property (bias_sample_hold_o ==
        (bias_enable_o && cfg_i.bias_low_power)) else $error("bias hold wrong");
    a_ship_isolate: assert property (state_o == OPC_SHIP |->
        !battery_connect_o && !host_access_enable_o) else $error("ship not isolated");
    a_ship_reset: assert property ($rose(state_o == OPC_SHIP) |->
        ##[0:1] config_register_reset_o) else $error("no reset on ship entry");
    a_reset_pulse: assert property (config_register_reset_o |=>
        !config_register_reset_o) else $error("reset pulse too long");
    a_fall_pulse: assert property (key_fall_interrupt_o |=> !key_fall_interrupt_o)
        else $error("fall pulse too long");
    a_fall_level: assert property (key_fall_interrupt_o |-> ##[0:1] !key_level_status_o)
        else $error("fall without low level");
    a_rise_level: assert property (key_rise_interrupt_o |-> ##[0:1] key_level_status_o)
        else $error("rise without high level");
    a_standby_first: assert property ($rose(state_o == OPC_RES_ON) |->
        $past(state_o) == OPC_STANDBY) else $error("resource-on skipped standby");
    a_bias_standby: assert property (state_o == OPC_STANDBY |-> bias_enable_o)
        else $error("bias off in standby");
    a_bias_shutdown: assert property (state_o == OPC_SHUTDOWN |-> !bias_enable_o)
        else $error("bias on in shutdown");
    a_fault_off: assert property ($rose(mon_i.sys_uv || mon_i.sys_ov || mon_i.over_temp) &&
        state_o != OPC_SHIP |-> ##[1:12] state_o == OPC_SHUTDOWN)
        else $error("fault did not shut down");

    // Main scenarios reached.
    c_ship: cover property ($rose(state_o == OPC_SHIP));
    c_fall: cover property (key_fall_interrupt_o);
    c_res_on: cover property ($rose(state_o == OPC_RES_ON));
endmodule : opc_onoff_ctrl_chk

bind opc_onoff_ctrl opc_onoff_ctrl_chk chk_u (.sys_clk_i, .resetn_i,
    .charger_input_quality_i, .mon_i, .cfg_i, .state_o, .bias_enable_o,
    .bias_sample_hold_o, .battery_connect_o, .host_access_enable_o,
    .config_register_reset_o, .key_level_status_o, .key_rise_interrupt_o,
    .key_fall_interrupt_o, .key_pullup_strong_o, .always_on_from_charger_o);

// file: test/opc_key_model.sv
/*
 * Behavioural on-key: a contact with a pullup, driven by bench commands.
 * Assumes the bench holds press long enough for every hold time it tests.
 */
`timescale 1ns/1ps
module opc_key_model (
    // Clock.
    input wire logic sys_clk_i,
    // Commands from the bench.
    input wire logic press_i,
    input wire logic chatter_i,
    // Pin toward the device, active low.
    output logic on_key_n_o
);
    logic phase = 1'b0; // Bounce phase, flips every clock.

    // Bouncing contacts flip far faster than any debounce window.
    always @(posedge sys_clk_i) begin
        phase <= ~phase;
    end
    // A held press pulls the pin low; the pullup restores it on release.
    assign on_key_n_o = chatter_i ? phase : !press_i;
endmodule : opc_key_model

// file: test/opc_onoff_ctrl_bench.sv
/*
 * Self-checking bench for the on/off controller with scaled tick counts.
 * Assumes the checker is bound and the key model stands on the pin.
 */
`timescale 1ns/1ps
module opc_onoff_ctrl_bench;
    import opc_pkg::*;
    localparam int TD = 10; // Clocks per tick, shortened for run time.
    localparam int MS = 20; // Short hard reset, in ticks.
    localparam int ML = 40; // Long hard reset, in ticks.
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic press = 1'b0;
    logic chatter = 1'b0;
    logic on_key_n_i;
    logic [1:0] charger_input_quality_i = 2'h0;
    opc_mon_t mon_i = '0;
    opc_res_t res_i = '0;
    opc_cfg_t cfg_i = '0;
    opc_state_t state_o;
    opc_state_t prev = OPC_SHUTDOWN;
    logic bias_enable_o, bias_sample_hold_o, battery_connect_o, ship_sys_from_charger_o;
    logic host_access_enable_o, config_register_reset_o, key_level_status_o;
    logic key_rise_interrupt_o, key_fall_interrupt_o, regulator_wake_flag_o;
    logic long_press_reset_flag_o, key_pullup_strong_o, always_on_from_charger_o;
    opc_state_t exp_q[$]; // Expected state moves, oldest first.
    logic [5:0] fm [5] = '{6'h20, 6'h10, 6'h08, 6'h01, 6'h00}; // Fault table.
    int fails = 0;
    int checks_done = 0;
    int seed = 22653;
    int n;

    opc_onoff_ctrl #(.TICK_DIV(TD), .MRST_SHORT(MS), .MRST_LONG(ML), .SHIP_EXIT(5)) dut_u (
        .sys_clk_i, .resetn_i, .on_key_n_i, .charger_input_quality_i, .mon_i, .res_i,
        .cfg_i, .state_o, .bias_enable_o, .bias_sample_hold_o, .battery_connect_o,
        .ship_sys_from_charger_o, .host_access_enable_o, .config_register_reset_o,
        .key_level_status_o, .key_rise_interrupt_o, .key_fall_interrupt_o,
        .regulator_wake_flag_o, .long_press_reset_flag_o, .key_pullup_strong_o,
        .always_on_from_charger_o);
    opc_key_model key_u (.sys_clk_i, .press_i(press), .chatter_i(chatter),
        .on_key_n_o(on_key_n_i));

    // The clock runs at 100 MHz.
    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic check_state(input opc_state_t e, input opc_state_t s);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("unexpected state: expected %0d seen %0d", e, s);
        end
    endtask : check_state

    task automatic check_bit(input string nm, input logic e, input logic s);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s: expected %b seen %b", nm, e, s);
        end
    endtask : check_bit

    task automatic ticks(input int k);
        repeat (k * TD) @(posedge sys_clk_i);
    endtask : ticks

    // Bounded wait of up to 2000 clocks; a miss returns silently and leaves later checks to fail.
    task automatic wait_state(input opc_state_t s);
        int c = 0;
        while (state_o !== s && c < 2000) begin
            @(posedge sys_clk_i);
            c++;
        end
    endtask : wait_state

    // Hold the counting level and time the shutdown it causes.
    task automatic hard_reset(input logic sel, input logic mode, input int lim);
        int c = 0;
        logic seen = 1'b0;
        @(posedge sys_clk_i);
        cfg_i.hard_reset_time_select <= sel;
        cfg_i.key_switch_type <= mode;
        press <= !mode;
        while (state_o !== OPC_SHUTDOWN && c < 1000) begin
            @(posedge sys_clk_i);
            c++;
            seen = seen | long_press_reset_flag_o;
        end
        check_bit("reset_time", 1'b1, c >= lim * TD && c <= (lim + 5) * TD);
        check_bit("long_press_flag", 1'b1, seen);
        press <= 1'b0;
        cfg_i.key_switch_type <= 1'b0;
        wait_state(OPC_RES_ON);
    endtask : hard_reset

    task automatic enter_ship;
        exp_q.push_back(OPC_SHIP);
        @(posedge sys_clk_i);
        cfg_i.software_power_request <= SWREQ_SHIP;
        wait_state(OPC_SHIP);
        cfg_i.software_power_request <= 2'h0;
    endtask : enter_ship

    task automatic back_on;
        exp_q.push_back(OPC_STANDBY);
        exp_q.push_back(OPC_RES_ON);
    endtask : back_on

    task automatic complete_run;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run

    // Each state move is matched against the oldest note.
    always @(posedge sys_clk_i) begin
        #1;
        if (resetn_i && state_o !== prev) begin
            check_state(exp_q.size() > 0 ? exp_q.pop_front() : prev, state_o);
            prev = state_o;
        end
    end

    // A hang is cut short well past the expected run length.
    initial begin
        repeat (30000) @(posedge sys_clk_i);
        fails++;
        complete_run();
    end

    initial begin
        repeat (10) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        ticks(2);
        check_bit("key_level", 1'b1, key_level_status_o);
        chatter <= 1'b1;
        repeat (8) @(posedge sys_clk_i);
        chatter <= 1'b0;
        ticks(3);
        check_state(OPC_SHUTDOWN, state_o);
        check_bit("key_level", 1'b1, key_level_status_o);
        back_on();
        press <= 1'b1;
        wait_state(OPC_RES_ON);
        check_bit("wake", 1'b1, regulator_wake_flag_o);
        check_bit("key_level", 1'b0, key_level_status_o);
        press <= 1'b0;
        res_i.regulator_enable <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk_i);
            n = $random(seed);
            cfg_i.key_pullup_weak <= n[0];
            cfg_i.input_suspend <= n[1];
            cfg_i.bias_low_power <= n[2];
            charger_input_quality_i <= n[4:3];
            @(posedge sys_clk_i);
            #1;
            check_bit("pullup", !n[0], key_pullup_strong_o);
            check_bit("aon", n[4:3] == 2'h3 && !n[1], always_on_from_charger_o);
        end
        charger_input_quality_i <= 2'h0;
        for (int k = 0; k < 5; k++) begin
            exp_q.push_back(OPC_SHUTDOWN);
            @(posedge sys_clk_i);
            mon_i <= opc_mon_t'(fm[k]);
            cfg_i.software_power_request <= (k == 4) ? SWREQ_OFF : 2'h0;
            ticks(4);
            check_state(OPC_SHUTDOWN, state_o);
            back_on();
            mon_i <= '0;
            cfg_i.software_power_request <= 2'h0;
            wait_state(OPC_RES_ON);
        end
        enter_ship();
        check_bit("ship_chg", 1'b0, ship_sys_from_charger_o);
        press <= 1'b1;
        ticks(12);
        check_state(OPC_SHIP, state_o);
        exp_q.push_back(OPC_SHUTDOWN);
        back_on();
        mon_i.sys_low <= 1'b1;
        wait_state(OPC_RES_ON);
        press <= 1'b0;
        mon_i.sys_low <= 1'b0;
        charger_input_quality_i <= CHG_QUAL_VALID;
        enter_ship();
        ticks(1);
        check_bit("ship_chg", 1'b1, ship_sys_from_charger_o);
        charger_input_quality_i <= CHG_QUAL_NONE;
        mon_i.sys_low <= 1'b1;
        ticks(3);
        check_state(OPC_SHIP, state_o);
        exp_q.push_back(OPC_SHUTDOWN);
        back_on();
        charger_input_quality_i <= CHG_QUAL_VALID;
        wait_state(OPC_RES_ON);
        mon_i.sys_low <= 1'b0;
        charger_input_quality_i <= CHG_QUAL_NONE;
        enter_ship();
        exp_q.push_back(OPC_SHUTDOWN);
        back_on();
        mon_i.battery_node_low <= 1'b1;
        wait_state(OPC_SHUTDOWN);
        mon_i.battery_node_low <= 1'b0;
        wait_state(OPC_RES_ON);
        check_bit("battery_node_con", 1'b1, battery_connect_o);
        press <= 1'b1;
        ticks(15);
        press <= 1'b0;
        ticks(5);
        // Long debounce: the press is not taken early, and is taken in the end.
        cfg_i.key_debounce_select <= 1'b1;
        press <= 1'b1;
        ticks(250);
        check_bit("key_level", 1'b1, key_level_status_o);
        ticks(55);
        check_bit("key_level", 1'b0, key_level_status_o);
        cfg_i.key_debounce_select <= 1'b0;
        press <= 1'b0;
        ticks(5);
        exp_q.push_back(OPC_SHUTDOWN);
        back_on();
        hard_reset(1'b0, 1'b0, MS);
        exp_q.push_back(OPC_SHUTDOWN);
        back_on();
        hard_reset(1'b1, 1'b1, ML);
        ticks(2);
        check_bit("queue_empty", 1'b1, exp_q.size() == 0);
        complete_run();
    end
endmodule : opc_onoff_ctrl_bench
